//--- src/ssrc_sync_reset_control.sv
// Contract
// [R1] capture reference pulse on sampling clock rise
// [R2] assertion is pin rise or soft bit rise
// [R3] every assertion resets interleave clock divider
// [R4] assertions 1-2 spare oscillator and multiframe
// [R5] captured pulse aligns local multiframe boundary
// [R6] frame and multiframe clocks from device clock
// [R7] assertion also resets decimation filters; code resets them only with the oscillators (third assertion on, oscMask low)
// [R8] partner runs pulse before register programming
// [R9] programmable delay in pulse input path
// [R10] three 16-bit oscillators, register or pin select
// [R11] divider mask blocks pulses to divider
// [R12] oscillator mask blocks oscillator and link resets
// [R13] partner waits over 40 us after first pulse
// [R14] assertion index saturates at three
//
// Implementation choices: the strobed register port and the placing of the registers.
package ssrc_pkg;
    localparam int          ADDR_W      = 8;
    localparam int          DATA_W      = 32;
    localparam int          PHASE_W     = 16;
    localparam int          NCO_COUNT   = 3;
    localparam int          DELAY_TAPS  = 16;
    localparam int          TAP_W       = 4;
    // register byte addresses
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_DELAY   = 8'h04;
    localparam logic [7:0]  OFS_FRAME   = 8'h08;
    localparam logic [7:0]  OFS_STATUS  = 8'h0C;
    localparam logic [7:0]  OFS_NCO0    = 8'h10;
    localparam logic [7:0]  OFS_NCO1    = 8'h14;
    localparam logic [7:0]  OFS_NCO2    = 8'h18;
    // control field positions
    localparam int          CTRL_SOFT   = 0;
    localparam int          CTRL_DIVMSK = 1;
    localparam int          CTRL_OSCMSK = 2;
    localparam int          CTRL_SEL_LO = 4;
    localparam int          CTRL_GPIO   = 6;
    // status field positions
    localparam int          STAT_SETTLE = 2;
    localparam int          STAT_CNT_LO = 8;
    // reset values
    localparam logic [7:0]  FRAME_LEN_RST = 8'h03;
    localparam logic [7:0]  MF_LEN_RST    = 8'h0F;
    localparam logic [3:0]  DELAY_RST     = 4'h0;
    localparam logic [15:0] NCO_FREQ_RST  = 16'h0000;
    // settle time after the first pulse
    localparam int          SETTLE_US   = 40;
    localparam int          CLK_MHZ     = 50;
    localparam int          SETTLE_CYC  = SETTLE_US * CLK_MHZ;
    localparam int          SETTLE_W    = 12;
    localparam logic [1:0]  IDX_SAT     = 2'h3;
    localparam logic [1:0]  IDX_LATE    = 2'h2;
endpackage : ssrc_pkg

////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module ssrc_sync_reset_control (
    input  wire logic                            sys_clk,
    input  wire logic                            rst_b,
    input  wire logic                            ce,
    input  wire logic                            refPulsePin,
    input  wire logic [1:0]                      gpioNcoSel,
    input  wire logic [ssrc_pkg::ADDR_W-1:0]     regAddr,
    input  wire logic [ssrc_pkg::DATA_W-1:0]     regWrData,
    input  wire logic                            regWrEn,
    input  wire logic                            regRdEn,
    output logic      [ssrc_pkg::DATA_W-1:0]     regRdData,
    output logic                                 divRstPulse,
    output logic                                 ncoRstPulse,
    output logic                                 decimRstPulse,
    output logic      [1:0]                      divPhase,
    output logic                                 frameBoundary,
    output logic                                 mfBoundary,
    output logic      [ssrc_pkg::PHASE_W-1:0]    ncoPhase
);
    import ssrc_pkg::*;

    typedef struct packed {
        logic                               pinSample;
        logic                               pinPrev;
        logic                               softBit;
        logic                               divMask;
        logic                               oscMask;
        logic [1:0]                         ncoSelReg;
        logic                               useGpioSel;
        logic [TAP_W-1:0]                   delayTap;
        logic [7:0]                         frameLen;
        logic [7:0]                         mfLen;
        logic [NCO_COUNT-1:0][PHASE_W-1:0]  ncoFreq;
        logic [NCO_COUNT-1:0][PHASE_W-1:0]  ncoAcc;
        logic [1:0]                         assertIdx;
        logic [SETTLE_W-1:0]                settleCnt;
        logic                               settleDone;
        logic [7:0]                         pulseCount;
        logic [1:0]                         clkDiv;
        logic [7:0]                         frameCnt;
        logic [7:0]                         mfCnt;
        logic                               frameClk;
        logic                               mfClk;
        logic                               divRst;
        logic                               ncoRst;
        logic                               decimRst;
        logic [PHASE_W-1:0]                 phaseOut;
        logic [DATA_W-1:0]                  rdData;
    } ssrc_state_t;

    ssrc_state_t state_reg;
    ssrc_state_t state_next;
    logic        delayedPin;
    logic        softRise;
    logic        assertEvt;
    logic        lateEvt;
    logic [1:0]  selNco;

    ////////////////////////////////////////////////////////////////////////////
    // input delay so the pulse can be skewed against the sampling clock
    ssrc_pulse_delay u_delay (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .ce       (ce),
        .pulseIn  (state_reg.pinSample),
        .tapSel   (state_reg.delayTap),
        .pulseOut (delayedPin)
    ); // see [R9]

    ////////////////////////////////////////////////////////////////////////////
    // assertion detection from either source
    assign softRise  = regWrEn && (regAddr == OFS_CTRL) && regWrData[CTRL_SOFT]
                       && !state_reg.softBit; // see [R2]
    assign assertEvt = (delayedPin && !state_reg.pinPrev) || softRise; // see [R2]
    assign lateEvt   = assertEvt && (state_reg.assertIdx >= IDX_LATE); // see [R4]
    assign selNco    = state_reg.useGpioSel ? gpioNcoSel : state_reg.ncoSelReg; // see [R10]

    // next state: capture, counters, sync resets, register port
    always_comb begin
        state_next = state_reg;
        state_next.pinSample = refPulsePin; // see [R1]
        state_next.pinPrev   = delayedPin;
        state_next.divRst    = 1'b0;
        state_next.ncoRst    = 1'b0;
        state_next.decimRst  = 1'b0;
        state_next.frameClk  = 1'b0;
        state_next.mfClk     = 1'b0;
        state_next.rdData    = '0;

        // free running divider, oscillators and frame counters
        state_next.clkDiv = state_reg.clkDiv + 2'h1;
        for (int i = 0; i < NCO_COUNT; i++) begin
            state_next.ncoAcc[i] = state_reg.ncoAcc[i] + state_reg.ncoFreq[i];
        end // see [R10]
        if (state_reg.frameCnt >= state_reg.frameLen) begin
            state_next.frameCnt = 8'h00;
            state_next.frameClk = 1'b1;
            if (state_reg.mfCnt >= state_reg.mfLen) begin
                state_next.mfCnt = 8'h00;
                state_next.mfClk = 1'b1;
            end else begin
                state_next.mfCnt = state_reg.mfCnt + 8'h01;
            end
        end else begin
            state_next.frameCnt = state_reg.frameCnt + 8'h01;
        end // see [R6]

        // settle timer starts on the first assertion, status only
        if (state_reg.assertIdx != 2'h0 && !state_reg.settleDone) begin
            if (state_reg.settleCnt >= SETTLE_W'(SETTLE_CYC - 1)) begin
                state_next.settleDone = 1'b1;
            end else begin
                state_next.settleCnt = state_reg.settleCnt + SETTLE_W'(1);
            end
        end

        // index counts every assertion until it saturates at three, masks only gate the resets
        if (assertEvt) begin
            state_next.pulseCount = state_reg.pulseCount + 8'h01;
            if (state_reg.assertIdx != IDX_SAT) begin
                state_next.assertIdx = state_reg.assertIdx + 2'h1;
            end // see [R14]
            if (!state_reg.divMask) begin
                state_next.clkDiv = 2'h0;
                state_next.divRst = 1'b1;
            end // see [R3] [R11]
        end
        if (lateEvt && !state_reg.oscMask) begin
            for (int i = 0; i < NCO_COUNT; i++) begin
                state_next.ncoAcc[i] = '0;
            end
            state_next.ncoRst   = 1'b1; // see [R4] [R12]
            state_next.decimRst = 1'b1; // see [R7]
            state_next.frameCnt = 8'h00;
            state_next.mfCnt    = 8'h00;
            state_next.frameClk = 1'b1;
            state_next.mfClk    = 1'b1; // see [R5]
        end

        // selected oscillator phase, codes above two pick the last one
        state_next.phaseOut = (selNco >= 2'h2) ? state_next.ncoAcc[2]
                                                : state_next.ncoAcc[selNco];

        // register writes
        if (regWrEn) begin
            case (regAddr)
                OFS_CTRL: begin
                    state_next.softBit    = regWrData[CTRL_SOFT];
                    state_next.divMask    = regWrData[CTRL_DIVMSK];
                    state_next.oscMask    = regWrData[CTRL_OSCMSK];
                    state_next.ncoSelReg  = regWrData[CTRL_SEL_LO +: 2];
                    state_next.useGpioSel = regWrData[CTRL_GPIO];
                end
                OFS_DELAY: state_next.delayTap = regWrData[TAP_W-1:0];
                OFS_FRAME: begin
                    state_next.frameLen = regWrData[7:0];
                    state_next.mfLen    = regWrData[15:8];
                end
                OFS_NCO0: state_next.ncoFreq[0] = regWrData[PHASE_W-1:0];
                OFS_NCO1: state_next.ncoFreq[1] = regWrData[PHASE_W-1:0];
                OFS_NCO2: state_next.ncoFreq[2] = regWrData[PHASE_W-1:0];
                default: ;
            endcase
        end

        // register reads, data valid one cycle after the strobe
        if (regRdEn) begin
            case (regAddr)
                OFS_CTRL: begin
                    state_next.rdData[CTRL_SOFT]        = state_reg.softBit;
                    state_next.rdData[CTRL_DIVMSK]      = state_reg.divMask;
                    state_next.rdData[CTRL_OSCMSK]      = state_reg.oscMask;
                    state_next.rdData[CTRL_SEL_LO +: 2] = state_reg.ncoSelReg;
                    state_next.rdData[CTRL_GPIO]        = state_reg.useGpioSel;
                end
                OFS_DELAY:  state_next.rdData[TAP_W-1:0] = state_reg.delayTap;
                OFS_FRAME:  state_next.rdData[15:0] = {state_reg.mfLen, state_reg.frameLen};
                OFS_STATUS: begin
                    state_next.rdData[1:0]             = state_reg.assertIdx;
                    state_next.rdData[STAT_SETTLE]     = state_reg.settleDone;
                    state_next.rdData[STAT_CNT_LO +: 8] = state_reg.pulseCount;
                end
                OFS_NCO0: state_next.rdData[PHASE_W-1:0] = state_reg.ncoFreq[0];
                OFS_NCO1: state_next.rdData[PHASE_W-1:0] = state_reg.ncoFreq[1];
                OFS_NCO2: state_next.rdData[PHASE_W-1:0] = state_reg.ncoFreq[2];
                default: state_next.rdData = '0;
            endcase
        end
    end

    // one register bank, frozen while the clock enable is low
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg          <= '0;
            state_reg.frameLen <= FRAME_LEN_RST;
            state_reg.mfLen    <= MF_LEN_RST;
            state_reg.delayTap <= DELAY_RST;
            state_reg.ncoFreq  <= {NCO_COUNT{NCO_FREQ_RST}};
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the bank
    assign regRdData     = state_reg.rdData;
    assign divRstPulse   = state_reg.divRst;
    assign ncoRstPulse   = state_reg.ncoRst;
    assign decimRstPulse = state_reg.decimRst;
    assign divPhase      = state_reg.clkDiv;
    assign frameBoundary = state_reg.frameClk;
    assign mfBoundary    = state_reg.mfClk;
    assign ncoPhase      = state_reg.phaseOut;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    property p_capture;
        ce |=> state_reg.pinSample == $past(refPulsePin);
    endproperty
    a_capture: assert property (p_capture) else $error("pulse pin not captured"); // see [R1]

    property p_soft_rise;
        (regWrEn && regAddr == OFS_CTRL && regWrData[CTRL_SOFT] && !state_reg.softBit)
            |-> assertEvt;
    endproperty
    a_soft_rise: assert property (p_soft_rise) else $error("soft rise missed"); // see [R2]

    property p_div_reset;
        (ce && assertEvt && !state_reg.divMask) |=> divRstPulse && divPhase == 2'h0;
    endproperty
    a_div_reset: assert property (p_div_reset) else $error("divider not reset"); // see [R3]

    property p_early_spare;
        (ce && assertEvt && state_reg.assertIdx < IDX_LATE) |=> !ncoRstPulse;
    endproperty
    a_early_spare: assert property (p_early_spare) else $error("early nco reset"); // see [R4]

    property p_late_reset;
        (ce && lateEvt && !state_reg.oscMask)
            |=> ncoRstPulse && mfBoundary && ncoPhase == '0;
    endproperty
    a_late_reset: assert property (p_late_reset) else $error("late reset missing"); // see [R5]

    property p_decim;
        ncoRstPulse |-> decimRstPulse;
    endproperty
    a_decim: assert property (p_decim) else $error("decimator reset missing"); // see [R7]

    property p_div_mask;
        (ce && assertEvt && state_reg.divMask) |=> !divRstPulse;
    endproperty
    a_div_mask: assert property (p_div_mask) else $error("masked divider reset"); // see [R11]

    property p_osc_mask;
        (ce && state_reg.oscMask) |=> !ncoRstPulse;
    endproperty
    a_osc_mask: assert property (p_osc_mask) else $error("masked nco reset"); // see [R12]

    property p_saturate;
        (state_reg.assertIdx == IDX_SAT) |=> state_reg.assertIdx == IDX_SAT;
    endproperty
    a_saturate: assert property (p_saturate) else $error("index left saturation"); // see [R14]

    property p_mf_in_frame;
        mfBoundary |-> frameBoundary;
    endproperty
    a_mf_in_frame: assert property (p_mf_in_frame) else $error("mf edge off frame"); // see [R6]

    c_late_reset: cover property (ce && lateEvt && !state_reg.oscMask);
    c_saturated:  cover property (state_reg.assertIdx == IDX_SAT && assertEvt);
    c_masked_div: cover property (assertEvt && state_reg.divMask);
    c_settled:    cover property (state_reg.settleDone);
endmodule // ssrc_sync_reset_control
`default_nettype wire

//--- src/ssrc_pulse_delay.sv
`timescale 1ns/1ps
`default_nettype none
module ssrc_pulse_delay (
    input  wire logic                        sys_clk,
    input  wire logic                        rst_b,
    input  wire logic                        ce,
    input  wire logic                        pulseIn,
    input  wire logic [ssrc_pkg::TAP_W-1:0]  tapSel,
    output logic                             pulseOut
);
    import ssrc_pkg::*;

    typedef struct packed {
        logic [DELAY_TAPS-1:0] taps;
        logic                  out;
    } ssrc_delay_t;

    ssrc_delay_t dly_reg;
    ssrc_delay_t dly_next;

    ////////////////////////////////////////////////////////////////////////////
    // shift line with a registered tap, latency is tapSel plus two
    always_comb begin
        dly_next      = dly_reg;
        dly_next.taps = {dly_reg.taps[DELAY_TAPS-2:0], pulseIn};
        dly_next.out  = dly_reg.taps[tapSel]; // see [R9]
    end

    // changing the tap mid-pulse may clip or stretch one pulse
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dly_reg <= '0;
        end else if (ce) begin
            dly_reg <= dly_next;
        end
    end

    assign pulseOut = dly_reg.out;
endmodule // ssrc_pulse_delay
`default_nettype wire

//--- bench/ssrc_pulse_gen.sv
`timescale 1ns/1ps
`default_nettype none
module ssrc_pulse_gen (
    input  wire logic sys_clk,
    output logic      refPulsePin
);
    import ssrc_pkg::*;
    int unsigned edgeCnt   = 0;
    int unsigned firstEdge = 0;
    int unsigned nFired    = 0;

    // pin driven low from time zero, never left floating
    initial refPulsePin = 1'b0;
    // edge count, only to pace the second pulse
    always @(posedge sys_clk) edgeCnt <= edgeCnt + 1;

    ////////////////////////////////////////////////////////////////////////////
    // one pulse, level held across whole clock periods
    task automatic fire(input int width);
        // second pulse held off until the clock path loop has settled
        while (nFired == 1 && edgeCnt - firstEdge <= SETTLE_CYC) @(posedge sys_clk);
        @(posedge sys_clk);
        refPulsePin <= 1'b1;
        if (nFired == 0) firstEdge = edgeCnt;
        nFired++;
        repeat (width) @(posedge sys_clk);
        refPulsePin <= 1'b0;
    endtask
endmodule // ssrc_pulse_gen
`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ssrc_pkg::*;
    logic              sys_clk;
    logic              rst_b;
    logic              ce;
    logic              refPulsePin;
    logic [1:0]        gpioNcoSel;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData;
    logic              regWrEn;
    logic              regRdEn;
    logic [DATA_W-1:0] regRdData;
    logic              divRstPulse;
    logic              ncoRstPulse;
    logic              decimRstPulse;
    logic [1:0]        divPhase;
    logic              frameBoundary;
    logic              mfBoundary;
    logic [PHASE_W-1:0] ncoPhase;
    logic [31:0]       lfsrState;
    logic [31:0]       rdVal;
    logic [15:0]       freq [3];
    int                nMismatch = 0;
    int                numChecks = 0;
    int                cyc = 0;
    int                nDiv = 0;
    int                nNco = 0;
    int                divCyc = 0;
    int                tap;
    int                sel;

    ssrc_sync_reset_control u_ssrc_sync_reset_control (.sys_clk, .rst_b, .ce, .refPulsePin,
        .gpioNcoSel, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData, .divRstPulse,
        .ncoRstPulse, .decimRstPulse, .divPhase, .frameBoundary, .mfBoundary, .ncoPhase);
    ssrc_pulse_gen u_ssrc_pulse_gen (.sys_clk, .refPulsePin);

    // free running clock and edge count
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nextRand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string msg);
        numChecks++;
        if (got !== exp) begin
            nMismatch++;
            $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr   <= a;
        regWrData <= d;
        regWrEn   <= 1'b1;
        @(posedge sys_clk);
        regWrEn   <= 1'b0;
    endtask
    // read data only stand in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge sys_clk);
        regRdEn <= 1'b0;
        @(negedge sys_clk);
        rdVal = regRdData;
    endtask
    // pin pulse: reset pulses expected five edges on, plus the delay tap
    task automatic fireChk(input int eDiv, input int eNco);
        int d0 = nDiv;
        int n0 = nNco;
        int mark;
        @(negedge sys_clk);
        mark = cyc;
        u_ssrc_pulse_gen.fire(2);
        repeat (24) @(negedge sys_clk);
        cmp(nDiv - d0, eDiv, "divider resets");
        cmp(nNco - n0, eNco, "osc resets");
        if (eDiv > 0) cmp(divCyc - mark, 5 + tap, "pulse latency");
    endtask
    task automatic frameChk(input int fLen, input int mLen);
        int lastF = -1;
        int lastM = -1;
        repeat (300) begin
            @(negedge sys_clk);
            if (frameBoundary === 1'b1) begin
                if (lastF >= 0) cmp(cyc - lastF, fLen, "frame gap");
                lastF = cyc;
            end
            if (mfBoundary === 1'b1) begin
                if (lastM >= 0) cmp(cyc - lastM, fLen * mLen, "multiframe gap");
                lastM = cyc;
            end
        end
        // a stuck counter would otherwise leave the gaps unchecked
        cmp({30'h0, lastF >= 0, lastM >= 0}, 32'h0000_0003, "boundaries seen");
    endtask
    // accumulator step equals the selected frequency word
    task automatic ncoChk(input logic [15:0] f);
        logic [15:0] p0;
        repeat (3) @(negedge sys_clk);
        p0 = ncoPhase;
        @(negedge sys_clk);
        cmp(16'(ncoPhase - p0), f, "osc step");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", numChecks, nMismatch);
        if (nMismatch == 0 && numChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // reset pulses always come with their companions
    always @(negedge sys_clk) begin
        if (rst_b === 1'b1) begin
            cmp(decimRstPulse, ncoRstPulse, "decim reset");
            if (divRstPulse === 1'b1) begin
                nDiv++;
                divCyc = cyc;
                cmp(divPhase, 2'h0, "divider phase");
            end
            if (ncoRstPulse === 1'b1) begin
                nNco++;
                cmp({mfBoundary, frameBoundary, ncoPhase}, 18'h3_0000, "osc reset");
            end
        end
    end
    // watchdog, well beyond the expected few thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        nMismatch++;
        $display("BAD t=%0t watchdog", $time);
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        gpioNcoSel = 2'h0;
        regAddr = '0;
        regWrData = '0;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        lfsrState = 32'h216d_293c;
        tap = 0;
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(OFS_FRAME);
        cmp(rdVal, 32'h0000_0F03, "frame reset value");
        rd(OFS_CTRL);
        cmp(rdVal, 32'h0000_0000, "ctrl reset value");
        $display("reset values done");
        // index walk, second pulse after the settle time
        fireChk(1, 0);
        repeat (2100) @(posedge sys_clk);
        fireChk(1, 0);
        fireChk(1, 1);
        fireChk(1, 1);
        rd(OFS_STATUS);
        cmp(rdVal & 32'h0000_FF07, 32'h0000_0407, "status");
        // soft assertion is taken at the write edge, pulses stand the cycle after
        wr(OFS_CTRL, 32'h0000_0001);
        @(negedge sys_clk);
        cmp({30'h0, divRstPulse, ncoRstPulse}, 32'h0000_0003, "soft pulse");
        @(negedge sys_clk);
        cmp(nDiv + nNco, 8, "soft assertion");
        for (int m = 1; m < 4; m++) begin
            wr(OFS_CTRL, 32'(m << 1));
            fireChk(m[0] ? 0 : 1, m[1] ? 0 : 1);
        end
        wr(OFS_STATUS, 32'h0000_0000);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(OFS_STATUS);
        cmp(rdVal & 32'h0000_FF03, 32'h0000_0803, "status after masks");
        rd(8'h40);
        cmp(rdVal, 32'h0000_0000, "unmapped read");
        $display("index and mask tests done");
        // delay taps: one random, then the longest
        for (int k = 0; k < 2; k++) begin
            lfsrState = nextRand(lfsrState);
            tap = k ? 15 : int'(lfsrState[3:0]);
            wr(OFS_CTRL, 32'h0000_0000);
            wr(OFS_DELAY, 32'(tap));
            rd(OFS_DELAY);
            cmp(rdVal, 32'(tap), "delay readback");
            fireChk(1, 1);
        end
        // random frame and multiframe lengths, counters restarted by a pulse
        lfsrState = nextRand(lfsrState);
        wr(OFS_FRAME, {22'h0, lfsrState[9:8], 5'h0, lfsrState[2:0] | 3'h1});
        fireChk(1, 1);
        frameChk(int'(lfsrState[2:0] | 3'h1) + 1, int'(lfsrState[9:8]) + 1);
        $display("delay and frame tests done");
        // oscillator select by register code, then by pins
        for (int i = 0; i < 3; i++) begin
            lfsrState = nextRand(lfsrState);
            freq[i] = lfsrState[15:0];
            wr(OFS_NCO0 + 8'(4 * i), {16'h0000, freq[i]});
        end
        for (int s = 0; s < 8; s++) begin
            @(posedge sys_clk);
            gpioNcoSel <= 2'(3 - (s & 3));
            wr(OFS_CTRL, 32'(((s & 3) << 4) | ((s >> 2) << 6)));
            sel = (s < 4) ? s : 3 - (s & 3);
            ncoChk(freq[sel > 2 ? 2 : sel]);
        end
        $display("oscillator select done");
        // clock enable low: divider frozen and a write strobe ignored
        @(posedge sys_clk);
        ce <= 1'b0;
        @(negedge sys_clk);
        rdVal = {30'h0, divPhase};
        wr(OFS_DELAY, 32'h0000_0005);
        @(negedge sys_clk);
        cmp({30'h0, divPhase}, rdVal, "ce freeze");
        @(posedge sys_clk);
        ce <= 1'b1;
        rd(OFS_DELAY);
        cmp(rdVal, 32'h0000_000F, "ce strobe ignored");
        $display("clock enable done");
        close_out();
    end
endmodule // tb_top
`default_nettype wire
